// File: hw/rwp_reset_wdt_prescaler.sv
`timescale 1ns/1ns
`include "rwp_defs.svh"
// Functional notes
// - one 8-bit prescaler, routed by config bit 3
// - assign set: watchdog drives postscaler
// - assign clear: prescaler drives realtime counter
// - prescaler count never readable or writable
// - prescaler serves one user at once
// - any reset loads top program address
// - power-up sets latch holding core reset
// - delay timer waits for reset pin high
// - terminal count clears latch, releases core
// - full ten-bit delay only after power-on
// - brown-out holds reset until supply recovers
// - brown-out disabled by fuse config field
// - watchdog reset flags: 00 asleep, 01 active
// - pin reset asleep flags 10, else unchanged
module rwp_reset_wdt_prescaler #(
  parameter int         PC_W       = `RWP_PC_W,
  parameter logic [10:0] PC_TOP    = `RWP_PC_TOP,
  parameter int         PRE_W      = `RWP_PRE_W,
  parameter int         DRT_BITS   = `RWP_DRT_BITS,
  parameter int         DRT_SHORT  = `RWP_DRT_SHORT,
  parameter int         DRT_CYCLES = `RWP_DRT_CYCLES,
  parameter logic [1:0] BOR_OFF    = `RWP_BOR_OFF
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // register port
  input  wire logic [`RWP_ADDR_W-1:0] reg_addr,
  input  wire logic [`RWP_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`RWP_DATA_W-1:0] reg_rdata,
  // pins, analog monitors and fuses
  input  wire logic                   ext_reset_pin_n,
  input  wire logic                   brownout_low,
  input  wire logic                   brownout_cfg_b0,
  input  wire logic                   brownout_cfg_b1,
  input  wire logic                   wdt_enable,
  // core side
  input  wire logic                   powerdown_in,
  input  wire logic                   wdt_clear,
  output logic                        core_reset,
  output logic      [PC_W-1:0]        reset_vector,
  output logic                        realtime_tick,
  output logic                        timeout_flag,
  output logic                        powerdown_flag,
  output logic                        irq
);

  // ************************************************************
  // constants
  // ************************************************************
  localparam int DIV_RAW = DRT_CYCLES / (1 << DRT_BITS);
  localparam int DRT_DIV = (DIV_RAW < 1) ? 1 : DIV_RAW;     // cycles per delay tick
  localparam int DIV_W   = $clog2(DRT_DIV + 1);
  localparam logic [DIV_W-1:0]    DIV_LAST  = DIV_W'(DRT_DIV - 1);
  localparam logic [DRT_BITS-1:0] TERM_FULL = {DRT_BITS{1'b1}};
  localparam logic [DRT_BITS-1:0] TERM_SHRT = DRT_BITS'((1 << DRT_SHORT) - 1);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [4:0] pins_s;        // synchronised pin and fuse levels
  logic       pin_high;      // reset pin released
  logic       bo_low;        // supply below threshold
  logic [1:0] bor_cfg;       // brown-out config field
  logic       wdt_en;        // watchdog fuse enable

  rwp_sync2 #(
    .W (5)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({wdt_enable, brownout_cfg_b1, brownout_cfg_b0,
             brownout_low, ext_reset_pin_n}),
    .q     (pins_s)
  );

  assign pin_high = pins_s[0];
  assign bo_low   = pins_s[1];
  assign bor_cfg  = pins_s[3:2];
  assign wdt_en   = pins_s[4];

  // ************************************************************
  // brown-out qualification
  // ************************************************************
  logic bo_active;           // brown-out reset requested

  // the fuse field can switch brown-out reset off
  assign bo_active = bo_low && (bor_cfg != BOR_OFF);

  // ************************************************************
  // configuration and interrupt registers
  // ************************************************************
  logic [`RWP_DATA_W-1:0] cfg_reg;     // timer configuration
  logic [`RWP_EV_W-1:0]   istat_reg;   // sticky event bits
  logic [`RWP_EV_W-1:0]   imask_reg;   // event enables
  logic [`RWP_EV_W-1:0]   imask_next;  // mask after this edge
  logic [`RWP_EV_W-1:0]   events;      // one-cycle events
  logic [`RWP_EV_W-1:0]   w1c;         // bits written with one
  logic                   prescaler_assign_sel;         // prescaler to watchdog
  logic [2:0]             rate;        // divide-rate select

  assign prescaler_assign_sel  = cfg_reg[`RWP_CFG_PSA_BIT];
  assign rate = cfg_reg[`RWP_CFG_RATE_HI:0];

  // configuration write
  always_ff @(posedge clock)
  begin
    if (rst)
      cfg_reg <= `RWP_CFG_RST;
    else if (reg_wr && reg_addr == `RWP_ADDR_CFG)
      cfg_reg <= reg_wdata;
  end

  // mask after this edge, so irq never lags a mask write
  always_comb
  begin
    imask_next = imask_reg;
    if (reg_wr && reg_addr == `RWP_ADDR_IMASK)
      imask_next = reg_wdata[`RWP_EV_W-1:0];
  end

  // mask write
  always_ff @(posedge clock)
  begin
    if (rst)
      imask_reg <= `RWP_IMASK_RST;
    else
      imask_reg <= imask_next;
  end

  // write-one-to-clear; a new event wins over the clear
  always_comb
  begin
    w1c = '0;
    if (reg_wr && reg_addr == `RWP_ADDR_ISTAT)
      w1c = reg_wdata[`RWP_EV_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      istat_reg <= '0;
    else
      istat_reg <= (istat_reg & ~w1c) | events;
  end

  // level interrupt from the next status value
  always_ff @(posedge clock)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(((istat_reg & ~w1c) | events) & imask_next);
  end

  // ************************************************************
  // watchdog counter and shared prescaler
  // ************************************************************
  rwp_pkg::rwp_state_t state_reg;      // sequencer state
  rwp_pkg::rwp_state_t state_next;
  logic [7:0] wdt_cnt_reg;   // watchdog count
  logic       wdt_ovf;       // watchdog wrap
  logic       wdt_timeout;   // watchdog reset request
  logic       psa_prev_reg;  // last routing, to flush on change
  logic       pre_clear;     // flush the prescaler
  logic       pre_in;        // prescaler input tick
  logic       pre_out;       // prescaler output tick
  logic [3:0] pre_shift;     // log2 of division
  logic       running;       // core out of reset

  assign running = (state_reg == rwp_pkg::ST_RUN);
  assign wdt_ovf = running && wdt_en && (wdt_cnt_reg == 8'hFF);

  // watchdog counts instruction cycles while running
  always_ff @(posedge clock)
  begin
    if (rst || !running || wdt_clear)
      wdt_cnt_reg <= 8'h00;
    else if (wdt_en)
      wdt_cnt_reg <= wdt_cnt_reg + 8'h01;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      psa_prev_reg <= 1'b1;
    else
      psa_prev_reg <= prescaler_assign_sel;
  end

  // one source feeds the prescaler, chosen by the assign bit
  always_comb
  begin
    pre_in    = prescaler_assign_sel ? wdt_ovf : 1'b1;
    pre_shift = prescaler_assign_sel ? {1'b0, rate} : {1'b0, rate} + 4'h1;
    pre_clear = !running || (prescaler_assign_sel != psa_prev_reg) || (wdt_clear && prescaler_assign_sel);
  end

  // the running count stays inside, with no register path
  rwp_prescaler #(
    .W (PRE_W)
  ) u_pre (
    .clock    (clock),
    .rst      (rst),
    .clear    (pre_clear),
    .tick_in  (pre_in),
    .shift    (pre_shift),
    .tick_out (pre_out)
  );

  // postscaled or direct watchdog timeout
  assign wdt_timeout = prescaler_assign_sel ? pre_out : wdt_ovf;

  // realtime counter tick: prescaled or every cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      realtime_tick <= 1'b0;
    else
      realtime_tick <= running && (prescaler_assign_sel ? 1'b1 : pre_out);
  end

  // ************************************************************
  // reset sequencer
  // ************************************************************
  logic [DRT_BITS-1:0] drt_cnt_reg;    // delay reset timer
  logic [DIV_W-1:0]    drt_div_reg;    // delay tick divider
  logic                drt_tick;       // delay timer step
  logic                full_len_reg;   // power-on delay pending
  logic [DRT_BITS-1:0] drt_term;       // active terminal count
  logic                src_ext;        // pin reset in run
  logic                blocked;        // delay may not count

  assign drt_tick = (drt_div_reg == DIV_LAST);
  assign drt_term = full_len_reg ? TERM_FULL : TERM_SHRT;
  assign src_ext  = running && !pin_high;
  assign blocked  = !pin_high || bo_active;

  // next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      rwp_pkg::ST_HOLD:
        if (!blocked)
          state_next = rwp_pkg::ST_DELAY;
      rwp_pkg::ST_DELAY:
        if (blocked)
          state_next = rwp_pkg::ST_HOLD;
        else if (drt_tick && drt_cnt_reg == drt_term)
          state_next = rwp_pkg::ST_RUN;
      rwp_pkg::ST_RUN:
        if (wdt_timeout || blocked)
          state_next = rwp_pkg::ST_HOLD;
      default:
        state_next = rwp_pkg::ST_HOLD;
    endcase
  end

  // power-up sets the latch
  always_ff @(posedge clock)
  begin
    if (rst)
      state_reg <= rwp_pkg::ST_HOLD;
    else
      state_reg <= state_next;
  end

  // only power-on uses the full-length delay
  always_ff @(posedge clock)
  begin
    if (rst)
      full_len_reg <= 1'b1;
    else if (state_next == rwp_pkg::ST_RUN)
      full_len_reg <= 1'b0;
  end

  // delay timer counts only while the pin is high
  always_ff @(posedge clock)
  begin
    if (rst || state_reg != rwp_pkg::ST_DELAY || blocked)
    begin
      drt_div_reg <= '0;
      drt_cnt_reg <= '0;
    end
    else if (drt_tick)
    begin
      drt_div_reg <= '0;
      drt_cnt_reg <= drt_cnt_reg + 1'b1;
    end
    else
      drt_div_reg <= drt_div_reg + 1'b1;
  end

  // latch output and reset vector
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_reset   <= 1'b1;
      reset_vector <= PC_TOP[PC_W-1:0];
    end
    else
    begin
      core_reset   <= (state_next != rwp_pkg::ST_RUN);
      reset_vector <= PC_TOP[PC_W-1:0];
    end
  end

  // ************************************************************
  // timeout and power-down flags
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end
    else if (running && wdt_timeout)
    begin
      timeout_flag   <= 1'b0;
      powerdown_flag <= !powerdown_in;
    end
    else if (src_ext && powerdown_in)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
  end

  // interrupt events
  always_comb
  begin
    events                = '0;
    events[`RWP_EV_WDT]   = running && wdt_timeout;
    events[`RWP_EV_BOR]   = running && bo_active;
    events[`RWP_EV_EXT]   = src_ext;
    events[`RWP_EV_REL]   = !running && (state_next == rwp_pkg::ST_RUN);
  end

  // ************************************************************
  // register read port
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
      case (reg_addr)
        `RWP_ADDR_CFG:   reg_rdata <= cfg_reg;
        `RWP_ADDR_FLAGS: reg_rdata <= {1'b0, state_reg, full_len_reg,
                                       core_reset, timeout_flag, powerdown_flag};
        `RWP_ADDR_ISTAT: reg_rdata <= {4'h0, istat_reg};
        `RWP_ADDR_IMASK: reg_rdata <= {4'h0, imask_reg};
        default:         reg_rdata <= '0;
      endcase
    else
      reg_rdata <= '0;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_release;
    (state_reg == rwp_pkg::ST_RUN) && !core_reset;
  endsequence

  sequence s_reenter;
    (state_reg == rwp_pkg::ST_HOLD) && core_reset;
  endsequence

  a_latch_holds: assert property (!running |-> core_reset)
    else $error("core left reset while latch set");

  a_vector_top: assert property (core_reset |-> reset_vector == PC_TOP[PC_W-1:0])
    else $error("reset vector not top address");

  a_drt_waits_pin: assert property (!pin_high |=> drt_cnt_reg == '0)
    else $error("delay timer ran with pin low");

  a_drt_release: assert property (
      (state_reg == rwp_pkg::ST_DELAY) && !blocked && drt_tick
      && (drt_cnt_reg == drt_term) |=> s_release)
    else $error("no release at terminal count");

  a_short_delay: assert property (
      (state_reg == rwp_pkg::ST_DELAY) && !full_len_reg
      |-> drt_cnt_reg <= TERM_SHRT)
    else $error("short delay exceeded");

  a_brownout_hold: assert property (bo_active |=> s_reenter)
    else $error("brown-out did not hold reset");

  a_bor_disable: assert property ((bor_cfg == BOR_OFF) && running && pin_high
      && !wdt_timeout |=> running)
    else $error("brown-out left run while disabled");

  a_wdt_flags: assert property (running && wdt_timeout
      |=> {timeout_flag, powerdown_flag} == {1'b0, !$past(powerdown_in)})
    else $error("watchdog flags wrong");

  a_ext_sleep: assert property (src_ext && !wdt_timeout && powerdown_in
      |=> {timeout_flag, powerdown_flag} == 2'h2)
    else $error("pin reset flags wrong in power-down");

  a_ext_active: assert property (src_ext && !wdt_timeout && !powerdown_in
      |=> $stable({timeout_flag, powerdown_flag}))
    else $error("pin reset changed flags when active");

  a_rtc_direct: assert property (running && prescaler_assign_sel |=> realtime_tick)
    else $error("realtime tick missing with watchdog route");

endmodule : rwp_reset_wdt_prescaler

// File: hw/rwp_defs.svh
`ifndef RWP_DEFS_SVH
`define RWP_DEFS_SVH

// ************************************************************
// register map and fields
// ************************************************************
`define RWP_ADDR_W        4
`define RWP_DATA_W        8
`define RWP_ADDR_CFG      4'h0
`define RWP_ADDR_FLAGS    4'h1
`define RWP_ADDR_ISTAT    4'h2
`define RWP_ADDR_IMASK    4'h3
`define RWP_CFG_RST       8'hFF
`define RWP_CFG_PSA_BIT   3
`define RWP_CFG_RATE_HI   2
`define RWP_IMASK_RST     4'h0

// interrupt event bit positions
`define RWP_EV_W          4
`define RWP_EV_WDT        0
`define RWP_EV_BOR        1
`define RWP_EV_EXT        2
`define RWP_EV_REL        3

// ************************************************************
// reset sequencing
// ************************************************************
`define RWP_PC_W          11
`define RWP_PC_TOP        11'h7FF
`define RWP_PRE_W         8
`define RWP_DRT_BITS      10
`define RWP_DRT_SHORT     4
`define RWP_BOR_OFF       2'h3
`define RWP_DRT_MS        72
`define RWP_CLK_NS        10
`define RWP_DRT_CYCLES    (`RWP_DRT_MS * 1000000 / `RWP_CLK_NS)

`endif

// File: hw/rwp_pkg.sv
// ************************************************************
// shared types
// ************************************************************
package rwp_pkg;

  // reset sequencer states, one-hot
  typedef enum logic [2:0]
  {
    ST_HOLD  = 3'h1,
    ST_DELAY = 3'h2,
    ST_RUN   = 3'h4
  } rwp_state_t;

endpackage : rwp_pkg

// File: hw/rwp_sync2.sv
`timescale 1ns/1ns
// ************************************************************
// two-stage synchroniser for pin and analog levels
// ************************************************************
module rwp_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;  // first stage, read by q only

  // both stages clear to zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : rwp_sync2

// File: hw/rwp_prescaler.sv
`timescale 1ns/1ns
// ************************************************************
// shared power-of-two prescaler / postscaler
// ************************************************************
module rwp_prescaler #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // control
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [3:0] shift,
  // divided tick
  output logic            tick_out
);

  logic [W-1:0] count_reg;  // hidden running count
  logic [W:0]   span;       // 2^shift
  logic [W-1:0] mask;       // low shift bits set

  // divide by 2^shift: fire when the low bits are all ones
  always_comb
  begin
    span     = {{W{1'b0}}, 1'b1} << shift;
    mask     = W'(span - 1'b1);
    tick_out = tick_in && ((count_reg & mask) == mask);
  end

  // count every input tick
  always_ff @(posedge clock)
  begin
    if (rst || clear)
      count_reg <= '0;
    else if (tick_in)
      count_reg <= count_reg + 1'b1;
  end

endmodule : rwp_prescaler

// File: tb/rwp_supply_model.sv
`timescale 1ns/1ns
// ************************************************************
// reset pin circuit and supply monitors outside the block
// ************************************************************
module rwp_supply_model (
  // clock
  input  wire logic       clock,
  // commands from the bench
  input  wire logic       pin_down,
  input  wire logic       sag,
  input  wire logic [1:0] bor_cfg,
  // levels seen by the block
  output logic            ext_reset_pin_n,
  output logic            brownout_low,
  output logic            brownout_cfg_b0,
  output logic            brownout_cfg_b1
);
  // pin held low by a switch, released high by its pull-up
  always_ff @(posedge clock)
  begin
    ext_reset_pin_n <= ~pin_down;
  end

  // supply monitor and fuse field are plain levels
  always_ff @(posedge clock)
  begin
    brownout_low    <= sag;
    brownout_cfg_b0 <= bor_cfg[0];
    brownout_cfg_b1 <= bor_cfg[1];
  end
endmodule : rwp_supply_model

// File: tb/rwp_reset_wdt_prescaler_bench.sv
`timescale 1ns/1ns
module rwp_reset_wdt_prescaler_bench;
  localparam int DRTC = 2048;     // shortened delay, 2 cycles per tick
  localparam int LIMIT = 20000;   // cycle ceiling for the whole run
  logic        clock = 1'b0;      // 100 MHz clock
  logic        rst = 1'b1;        // synchronous reset
  logic [3:0]  reg_addr = 4'h0;   // register port
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        pin_down = 1'b1;   // model commands
  logic        sag = 1'b0;
  logic [1:0]  bor_cfg = 2'h3;
  logic        ext_reset_pin_n, brownout_low, brownout_cfg_b0, brownout_cfg_b1;
  logic        wdt_enable = 1'b0; // core side
  logic        powerdown_in = 1'b0;
  logic        wdt_clear = 1'b0;
  logic        core_reset, realtime_tick, timeout_flag, powerdown_flag, irq;
  logic [10:0] reset_vector;
  int          error_cnt = 0;     // mismatches
  int          tests_run = 0;     // comparisons
  int          cycle_cnt = 0;     // hang guard

  always #5 clock = ~clock;

  rwp_supply_model PM (.clock(clock), .pin_down(pin_down), .sag(sag), .bor_cfg(bor_cfg),
    .ext_reset_pin_n(ext_reset_pin_n), .brownout_low(brownout_low),
    .brownout_cfg_b0(brownout_cfg_b0), .brownout_cfg_b1(brownout_cfg_b1));

  rwp_reset_wdt_prescaler #(.DRT_CYCLES(DRTC)) DUT (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_reset_pin_n(ext_reset_pin_n), .brownout_low(brownout_low),
    .brownout_cfg_b0(brownout_cfg_b0), .brownout_cfg_b1(brownout_cfg_b1),
    .wdt_enable(wdt_enable), .powerdown_in(powerdown_in), .wdt_clear(wdt_clear),
    .core_reset(core_reset), .reset_vector(reset_vector), .realtime_tick(realtime_tick),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // value compare, four-state exact
  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // cycle count compare against a window
  task automatic chk_rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  // data stands in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [10:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = {3'h0, reg_rdata};
  endtask : reg_read

  // counts cycles until core_reset shows v
  task automatic wait_core(input logic v, output int n);
    n = 0;
    while (core_reset !== v && n < 5000)
    begin
      @(posedge clock);
      #1 n++;
    end
  endtask : wait_core

  // cycles between two realtime ticks
  task automatic tick_gap(output int n);
    n = 0;
    while (realtime_tick !== 1'b1 && n < 600)
    begin
      @(posedge clock);
      #1 n++;
    end
    n = 0;
    do
    begin
      @(posedge clock);
      #1 n++;
    end
    while (realtime_tick !== 1'b1 && n < 600);
  endtask : tick_gap

  function automatic logic [10:0] fl();
    return {9'h000, timeout_flag, powerdown_flag};
  endfunction : fl

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_power_on();
    int n;
    cyc(8);
    rst <= 1'b0;
    cyc(300);
    #1 chk_val({10'h000, core_reset}, 11'h001);
    chk_val(reset_vector, 11'h7FF);
    @(posedge clock);
    pin_down <= 1'b0;
    wait_core(1'b0, n);
    chk_rng(n, DRTC, DRTC + 12);
    chk_val(fl(), 11'h003);
    $display("test power_on done");
  endtask : t_power_on

  task automatic t_regs();
    logic [10:0] d, f;
    reg_read(4'h0, d);
    chk_val(d, 11'h0FF);
    reg_read(4'h3, d);
    chk_val(d, 11'h000);
    reg_read(4'h1, f);
    chk_val(f, 11'h043);
    reg_write(4'h1, 8'hAA);
    reg_read(4'h1, d);
    chk_val(d, f);
    reg_write(4'h7, 8'h55);
    reg_read(4'h7, d);
    chk_val(d, 11'h000);
    reg_write(4'h0, 8'h5A);
    reg_read(4'h0, d);
    chk_val(d, 11'h05A);
    $display("test registers done");
  endtask : t_regs

  task automatic t_irq();
    logic [10:0] d;
    reg_read(4'h2, d);
    chk_val(d, 11'h008);
    chk_val({10'h000, irq}, 11'h000);
    reg_write(4'h3, 8'h08);
    #1 chk_val({10'h000, irq}, 11'h001);
    reg_write(4'h2, 8'h08);
    #1 chk_val({10'h000, irq}, 11'h000);
    reg_read(4'h2, d);
    chk_val(d, 11'h000);
    $display("test irq done");
  endtask : t_irq

  task automatic t_realtime();
    int g;
    for (int r = 0; r < 8; r++)
    begin
      reg_write(4'h0, {5'h00, 3'(r)});
      tick_gap(g);
      tick_gap(g);
      chk_rng(g, 2 << r, 2 << r);
    end
    reg_write(4'h0, 8'h08);
    cyc(4);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      #1 chk_val({10'h000, realtime_tick}, 11'h001);
    end
    $display("test realtime done");
  endtask : t_realtime

  // one watchdog timeout from a clear pulse
  task automatic wdt_run(input logic [7:0] cfg, input logic pd, input int exp,
                         input logic [10:0] flg);
    int n;
    logic [10:0] d;
    reg_write(4'h0, cfg);
    powerdown_in <= pd;
    wdt_enable <= 1'b1;
    cyc(4);
    wdt_clear <= 1'b1;
    @(posedge clock);
    wdt_clear <= 1'b0;
    #1 wait_core(1'b1, n);
    chk_rng(n, exp - 2, exp + 6);
    @(posedge clock);
    wdt_enable <= 1'b0;
    cyc(2);
    #1 chk_val(fl(), flg);
    chk_val(reset_vector, 11'h7FF);
    reg_read(4'h2, d);
    chk_val(d & 11'h001, 11'h001);
    reg_write(4'h2, 8'h01);
    wait_core(1'b0, n);
    chk_rng(n, 1, 44);
    @(posedge clock);
    powerdown_in <= 1'b0;
  endtask : wdt_run

  task automatic t_watchdog();
    wdt_run(8'h09, 1'b0, 512, 11'h001);
    wdt_run(8'h03, 1'b1, 256, 11'h000);
    $display("test watchdog done");
  endtask : t_watchdog

  task automatic t_pin();
    int n;
    logic [10:0] f;
    for (int k = 0; k < 2; k++)
    begin
      f = (k == 0) ? fl() : 11'h002;
      @(posedge clock);
      powerdown_in <= k[0];
      pin_down <= 1'b1;
      cyc(10);
      #1 chk_val({10'h000, core_reset}, 11'h001);
      @(posedge clock);
      pin_down <= 1'b0;
      wait_core(1'b0, n);
      chk_rng(n, 32, 44);
      chk_val(fl(), f);
      @(posedge clock);
      powerdown_in <= 1'b0;
    end
    $display("test pin done");
  endtask : t_pin

  task automatic t_brownout();
    int n;
    logic [10:0] f;
    f = fl();
    @(posedge clock);
    bor_cfg <= 2'h0;
    cyc(5);
    sag <= 1'b1;
    cyc(8);
    #1 chk_val({10'h000, core_reset}, 11'h001);
    cyc(100);
    #1 chk_val({10'h000, core_reset}, 11'h001);
    @(posedge clock);
    sag <= 1'b0;
    wait_core(1'b0, n);
    chk_rng(n, 32, 44);
    chk_val(fl(), f);
    @(posedge clock);
    bor_cfg <= 2'h3;
    cyc(5);
    sag <= 1'b1;
    cyc(50);
    #1 chk_val({10'h000, core_reset}, 11'h000);
    @(posedge clock);
    sag <= 1'b0;
    $display("test brownout done");
  endtask : t_brownout

  // ************************************************************
  // main sequence and hang guard
  // ************************************************************
  always @(posedge clock)
  begin
    cycle_cnt++;
    if (cycle_cnt == LIMIT)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  initial
  begin
    t_power_on();
    t_regs();
    t_irq();
    t_realtime();
    t_watchdog();
    t_pin();
    t_brownout();
    end_of_test();
  end
endmodule : rwp_reset_wdt_prescaler_bench
